//--- ucr_defs.svh
// offsets, field positions, masks and reset values of the register bank
// Contract
// RULE1: shortcut links a local event to a task
// RULE2: end-of-receive with bit set starts receive
// RULE3: end-of-receive with bit set stops receive
// RULE4: separate enable bits for both clear-to-send events
// RULE5: enable bits for the four receive events
// RULE6: enable bits for the four transmit events
// RULE7: error interrupts only while its enable set
// RULE8: irq is any flag and enable; reset zero
// RULE9: set register writes ones into enables
// RULE10: event flag reads one once generated
`ifndef UCR_DEFS_SVH
`define UCR_DEFS_SVH

`define UCR_AW 12
`define UCR_OFS_LINKS 12'h200
`define UCR_OFS_IRQ_EN 12'h300
`define UCR_OFS_EN_SET 12'h304
`define UCR_OFS_EN_CLR 12'h308
`define UCR_OFS_EVSTAT 12'h400

`define UCR_BIT_START_SHORT 5
`define UCR_BIT_STOP_SHORT 6

`define UCR_BIT_CTS 0
`define UCR_BIT_CTS_OFF 1
`define UCR_BIT_RXRDY 2
`define UCR_BIT_RXEND 4
`define UCR_BIT_TXSENT 7
`define UCR_BIT_TXEND 8
`define UCR_BIT_ERROR 9
`define UCR_BIT_RXTMO 17
`define UCR_BIT_RXBEGAN 19
`define UCR_BIT_TXBEGAN 20
`define UCR_BIT_TXHALTED 22

`define UCR_LINKS_MASK 32'h0000_0060
`define UCR_IRQ_EN_MASK 32'h005A_0397
`define UCR_LINKS_RESET 32'h0000_0000
`define UCR_IRQ_EN_RESET 32'h0000_0000

`endif

//--- ucr_event_flags.sv
// sticky event flags, set by hardware pulses, cleared by software
`timescale 1ns/1ps
`default_nettype none
module ucr_event_flags
  import ucr_pkg::*;
#(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // set and clear vectors
  input wire logic [W-1:0] set_vec,
  input wire logic [W-1:0] clr_vec,
  // flag state
  output logic [W-1:0] flags_ff
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      wire logic nxt_flag;
      // a set in the clearing cycle wins
      assign nxt_flag = set_vec[i] | (flags_ff[i] & ~clr_vec[i]); // RULE10
      always_ff @(posedge clk) begin
        if (!rstn) begin
          flags_ff[i] <= 1'b0;
        end else begin
          flags_ff[i] <= nxt_flag;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

//--- ucr_pkg.sv
// types shared by the shortcut and interrupt enable register bank
package ucr_pkg;

  typedef logic [31:0] ucr_word_t;

  typedef enum {
    UCR_SEL_NONE,
    UCR_SEL_LINKS,
    UCR_SEL_IRQ_EN,
    UCR_SEL_EN_SET,
    UCR_SEL_EN_CLR,
    UCR_SEL_EVSTAT
  } ucr_sel_t;

endpackage

//--- ucr_regs.sv
// shortcut and interrupt enable register bank of the uart peripheral
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ucr_defs.svh"
module ucr_regs
  import ucr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [`UCR_AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // event pulses from the uart core
  input wire logic cts_asserted_event,
  input wire logic clear_to_send_deasserted_event,
  input wire logic rx_byte_ready_event,
  input wire logic rx_buffer_end_event,
  input wire logic tx_byte_sent_event,
  input wire logic tx_buffer_end_event,
  input wire logic error_event,
  input wire logic rx_timeout_event,
  input wire logic rx_began_event,
  input wire logic tx_began_event,
  input wire logic tx_halted_event,
  // task triggers and interrupt
  output logic rx_begin_task,
  output logic rx_halt_task,
  output logic irq
);

  ucr_word_t links_ff;
  ucr_word_t irq_en_ff;
  ucr_word_t rdata_ff;
  logic rx_begin_task_ff;
  logic rx_halt_task_ff;
  logic irq_ff;
  ucr_word_t flags;
  ucr_word_t ev_vec;
  ucr_sel_t sel;

  // address decode
  wire logic hit_links = (addr == `UCR_OFS_LINKS);
  wire logic hit_irq_en = (addr == `UCR_OFS_IRQ_EN);
  wire logic hit_set = (addr == `UCR_OFS_EN_SET);
  wire logic hit_clr = (addr == `UCR_OFS_EN_CLR);
  wire logic hit_ev = (addr == `UCR_OFS_EVSTAT);

  assign sel = hit_links ? UCR_SEL_LINKS :
               hit_irq_en ? UCR_SEL_IRQ_EN :
               hit_set ? UCR_SEL_EN_SET :
               hit_clr ? UCR_SEL_EN_CLR :
               hit_ev ? UCR_SEL_EVSTAT : UCR_SEL_NONE;

  wire ucr_word_t wmask_en = wdata & `UCR_IRQ_EN_MASK;
  wire logic wr_links = wr_en && (sel == UCR_SEL_LINKS);
  wire logic wr_irq_en = wr_en && (sel == UCR_SEL_IRQ_EN);
  wire logic wr_set = wr_en && (sel == UCR_SEL_EN_SET);
  wire logic wr_clr = wr_en && (sel == UCR_SEL_EN_CLR);
  wire logic wr_ev = wr_en && (sel == UCR_SEL_EVSTAT);

  // next values
  wire ucr_word_t nxt_links = wr_links ? (wdata & `UCR_LINKS_MASK) : links_ff;
  wire ucr_word_t nxt_irq_en = wr_irq_en ? wmask_en : // RULE4 RULE5 RULE6 RULE7
                               wr_set ? (irq_en_ff | wmask_en) : // RULE9
                               wr_clr ? (irq_en_ff & ~wmask_en) : irq_en_ff;
  wire ucr_word_t nxt_rdata = !rd_en ? 32'h0000_0000 :
                              (sel == UCR_SEL_LINKS) ? links_ff :
                              (sel == UCR_SEL_IRQ_EN) ? irq_en_ff :
                              (sel == UCR_SEL_EN_SET) ? irq_en_ff : // RULE9
                              (sel == UCR_SEL_EN_CLR) ? irq_en_ff :
                              (sel == UCR_SEL_EVSTAT) ? flags : 32'h0000_0000;

  // shortcuts fire the tasks with no software action
  wire logic nxt_rx_begin = rx_buffer_end_event & links_ff[`UCR_BIT_START_SHORT]; // RULE1 RULE2
  wire logic nxt_rx_halt = rx_buffer_end_event & links_ff[`UCR_BIT_STOP_SHORT]; // RULE1 RULE3
  wire logic nxt_irq = |(flags & irq_en_ff); // RULE8 RULE7

  // event pulses placed at their bit positions
  always_comb begin
    ev_vec = 32'h0000_0000;
    ev_vec[`UCR_BIT_CTS] = cts_asserted_event;
    ev_vec[`UCR_BIT_CTS_OFF] = clear_to_send_deasserted_event;
    ev_vec[`UCR_BIT_RXRDY] = rx_byte_ready_event;
    ev_vec[`UCR_BIT_RXEND] = rx_buffer_end_event;
    ev_vec[`UCR_BIT_TXSENT] = tx_byte_sent_event;
    ev_vec[`UCR_BIT_TXEND] = tx_buffer_end_event;
    ev_vec[`UCR_BIT_ERROR] = error_event;
    ev_vec[`UCR_BIT_RXTMO] = rx_timeout_event;
    ev_vec[`UCR_BIT_RXBEGAN] = rx_began_event;
    ev_vec[`UCR_BIT_TXBEGAN] = tx_began_event;
    ev_vec[`UCR_BIT_TXHALTED] = tx_halted_event;
  end

  wire ucr_word_t ev_clr = wr_ev ? (wdata & `UCR_IRQ_EN_MASK) : 32'h0000_0000;

  ucr_event_flags #(
    .W(32)
  ) u_flags (
    .clk(clk),
    .rstn(rstn),
    .set_vec(ev_vec), // RULE10
    .clr_vec(ev_clr),
    .flags_ff(flags)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      links_ff <= `UCR_LINKS_RESET; // RULE8
      irq_en_ff <= `UCR_IRQ_EN_RESET; // RULE8
    end else begin
      links_ff <= nxt_links;
      irq_en_ff <= nxt_irq_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_ff <= 32'h0000_0000;
      rx_begin_task_ff <= 1'b0;
      rx_halt_task_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rx_begin_task_ff <= nxt_rx_begin;
      rx_halt_task_ff <= nxt_rx_halt;
      irq_ff <= nxt_irq;
    end
  end

  assign rdata = rdata_ff;
  assign rx_begin_task = rx_begin_task_ff;
  assign rx_halt_task = rx_halt_task_ff;
  assign irq = irq_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_start_short: assert property ( // RULE2
    (rx_buffer_end_event && links_ff[`UCR_BIT_START_SHORT]) |=> rx_begin_task_ff)
    else $error("start shortcut did not fire");
  a_short_only_linked: assert property ( // RULE1
    !(rx_buffer_end_event && links_ff[`UCR_BIT_START_SHORT]) |=> !rx_begin_task_ff)
    else $error("start task fired without shortcut");
  a_stop_short: assert property ( // RULE3
    rx_halt_task_ff == $past(rx_buffer_end_event && links_ff[`UCR_BIT_STOP_SHORT]))
    else $error("stop shortcut mismatch");
  a_halt_refused: assert property ( // RULE3
    !(rx_buffer_end_event && links_ff[`UCR_BIT_STOP_SHORT]) |=> !rx_halt_task_ff)
    else $error("stop task fired without shortcut");
  a_links_write: assert property ( // RULE2
    wr_en && addr == `UCR_OFS_LINKS |=> links_ff == ($past(wdata) & `UCR_LINKS_MASK))
    else $error("shortcut register write wrong");
  a_links_read: assert property ( // RULE1
    rd_en && addr == `UCR_OFS_LINKS |=> rdata_ff == $past(links_ff))
    else $error("shortcut register read wrong");

  a_cts_enables: assert property ( // RULE4
    wr_en && addr == `UCR_OFS_IRQ_EN |=> irq_en_ff[1:0] == $past(wdata[1:0]))
    else $error("clear-to-send enables not stored");
  a_enable_read: assert property ( // RULE4
    rd_en && addr == `UCR_OFS_IRQ_EN |=> rdata_ff == $past(irq_en_ff))
    else $error("enable register read wrong");
  a_clear_reg: assert property ( // RULE4
    wr_en && addr == `UCR_OFS_EN_CLR |=> irq_en_ff == ($past(irq_en_ff) & ~($past(wdata) & `UCR_IRQ_EN_MASK)))
    else $error("clear register write wrong");
  a_rx_enables: assert property ( // RULE5
    wr_en && addr == `UCR_OFS_IRQ_EN |=>
    {irq_en_ff[`UCR_BIT_RXRDY], irq_en_ff[`UCR_BIT_RXEND],
     irq_en_ff[`UCR_BIT_RXTMO], irq_en_ff[`UCR_BIT_RXBEGAN]} ==
    $past({wdata[`UCR_BIT_RXRDY], wdata[`UCR_BIT_RXEND], wdata[`UCR_BIT_RXTMO], wdata[`UCR_BIT_RXBEGAN]}))
    else $error("receive enables not stored");
  a_rx_gate: assert property ( // RULE5
    flags[`UCR_BIT_RXEND] && irq_en_ff[`UCR_BIT_RXEND] |=> irq_ff)
    else $error("enabled receive event gave no irq");
  a_tx_enables: assert property ( // RULE6
    wr_en && addr == `UCR_OFS_IRQ_EN |=>
    {irq_en_ff[`UCR_BIT_TXSENT], irq_en_ff[`UCR_BIT_TXEND],
     irq_en_ff[`UCR_BIT_TXBEGAN], irq_en_ff[`UCR_BIT_TXHALTED]} ==
    $past({wdata[`UCR_BIT_TXSENT], wdata[`UCR_BIT_TXEND], wdata[`UCR_BIT_TXBEGAN], wdata[`UCR_BIT_TXHALTED]}))
    else $error("transmit enables not stored");
  a_tx_gate: assert property ( // RULE6
    flags[`UCR_BIT_TXSENT] && irq_en_ff[`UCR_BIT_TXSENT] |=> irq_ff)
    else $error("enabled transmit event gave no irq");
  a_error_gated: assert property ( // RULE7
    (flags == (32'h0000_0001 << `UCR_BIT_ERROR)) && !irq_en_ff[`UCR_BIT_ERROR] |=> !irq_ff)
    else $error("error interrupt while disabled");
  a_error_raise: assert property ( // RULE7
    flags[`UCR_BIT_ERROR] && irq_en_ff[`UCR_BIT_ERROR] |=> irq_ff)
    else $error("enabled error gave no irq");

  a_regs_reset: assert property ( // RULE8
    $rose(rstn) |-> (links_ff == `UCR_LINKS_RESET) && (irq_en_ff == `UCR_IRQ_EN_RESET) && !irq_ff)
    else $error("registers not cleared by reset");
  a_irq_cause: assert property ( // RULE8
    ##1 irq_ff == |($past(flags) & $past(irq_en_ff)))
    else $error("irq does not follow flags and enables");
  a_set_reg: assert property ( // RULE9
    wr_en && addr == `UCR_OFS_EN_SET |=> irq_en_ff == ($past(irq_en_ff) | ($past(wdata) & `UCR_IRQ_EN_MASK)))
    else $error("set register write wrong");
  a_zero_set_keeps: assert property ( // RULE9
    wr_en && addr == `UCR_OFS_EN_SET && wdata == 32'h0000_0000 |=> irq_en_ff == $past(irq_en_ff))
    else $error("zero write to set register changed enables");
  a_set_read: assert property ( // RULE9
    rd_en && addr == `UCR_OFS_EN_SET |=> rdata_ff == $past(irq_en_ff))
    else $error("set register read wrong");
  a_flag_sticky: assert property ( // RULE10
    rx_began_event |=> flags[`UCR_BIT_RXBEGAN] ##1 (flags[`UCR_BIT_RXBEGAN] || $past(wr_ev)))
    else $error("event flag not held");
  a_flag_read: assert property ( // RULE10
    rd_en && addr == `UCR_OFS_EVSTAT |=> rdata_ff == $past(flags))
    else $error("event flag read wrong");
  a_set_wins: assert property ( // RULE10
    ev_vec[`UCR_BIT_ERROR] && ev_clr[`UCR_BIT_ERROR] |=> flags[`UCR_BIT_ERROR])
    else $error("clear won over a same-cycle event");

  c_start_short: cover property (rx_buffer_end_event && links_ff[`UCR_BIT_START_SHORT] ##1 rx_begin_task_ff);
  c_stop_short: cover property (rx_buffer_end_event && links_ff[`UCR_BIT_STOP_SHORT] ##1 rx_halt_task_ff);
  c_irq_raise: cover property (!irq_ff ##1 irq_ff);
  c_irq_fall: cover property (irq_ff ##1 !irq_ff);
  c_set_clear_same: cover property (ev_vec[`UCR_BIT_ERROR] && ev_clr[`UCR_BIT_ERROR]);

endmodule
`default_nettype wire

//--- ucr_regs_bench.sv
// self-checking bench for the shortcut and interrupt enable register bank
`timescale 1ns/1ps
`default_nettype none
module ucr_regs_bench
  import ucr_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] addr = 12'h000;
  ucr_word_t wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [10:0] ev = 11'h000;
  ucr_word_t rdata;
  logic rx_begin_task;
  logic rx_halt_task;
  logic irq;
  int fail_count = 0;
  int checked = 0;
  int pos [11] = '{0, 1, 2, 4, 7, 8, 9, 17, 19, 20, 22};

  always #25 clk = ~clk;

  ucr_regs i_ucr_regs (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .cts_asserted_event(ev[0]), .clear_to_send_deasserted_event(ev[1]), .rx_byte_ready_event(ev[2]),
    .rx_buffer_end_event(ev[3]), .tx_byte_sent_event(ev[4]), .tx_buffer_end_event(ev[5]),
    .error_event(ev[6]), .rx_timeout_event(ev[7]), .rx_began_event(ev[8]), .tx_began_event(ev[9]),
    .tx_halted_event(ev[10]), .rx_begin_task(rx_begin_task), .rx_halt_task(rx_halt_task), .irq(irq)
  );

  task automatic chk(input string what, input ucr_word_t seen, input ucr_word_t exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input ucr_word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read strobe, data sampled in the following cycle only
  task automatic rdchk(input logic [11:0] a, input ucr_word_t exp, input string what);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask

  // one-cycle event pulse, returns just after the edge that takes it
  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 11'h001 << i;
    @(posedge clk);
    ev <= 11'h000;
    #1;
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    fail_count++;
    complete_run;
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("irq after reset", {31'h0, irq}, 32'h0);
    rdchk(12'h200, 32'h0000_0000, "shortcuts reset");
    rdchk(12'h300, 32'h0000_0000, "enables reset");
    wr(12'h200, 32'hFFFF_FFFF);
    rdchk(12'h200, 32'h0000_0060, "shortcut bits");
    wr(12'h300, 32'hFFFF_FFFF);
    rdchk(12'h300, 32'h005A_0397, "enable bits");
    rdchk(12'h104, 32'h0000_0000, "unmapped read");
    wr(12'h300, 32'h0000_0000);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      wr(12'h200, 32'(s) << 5);
      pulse(3);
      chk("start task", {31'h0, rx_begin_task}, 32'(s & 1));
      chk("stop task", {31'h0, rx_halt_task}, 32'((s >> 1) & 1));
      @(posedge clk);
      #1;
      chk("task pulse length", {30'h0, rx_begin_task, rx_halt_task}, 32'h0);
    end
    wr(12'h200, 32'h0000_0000);
    wr(12'h400, 32'hFFFF_FFFF);
    $display("test shortcuts done");
    for (int i = 0; i < 11; i++) begin
      pulse(i);
      @(posedge clk);
      #1;
      chk("masked irq", {31'h0, irq}, 32'h0);
      rdchk(12'h400, 32'h1 << pos[i], "event flag");
      wr(12'h304, 32'h1 << pos[i]);
      @(posedge clk);
      #1;
      chk("enabled irq", {31'h0, irq}, 32'h1);
      wr(12'h304, 32'h0000_0000);
      rdchk(12'h304, 32'h1 << pos[i], "enable after zero set");
      wr(12'h400, 32'h1 << pos[i]);
      @(posedge clk);
      #1;
      chk("irq after flag clear", {31'h0, irq}, 32'h0);
      wr(12'h308, 32'h1 << pos[i]);
      rdchk(12'h300, 32'h0000_0000, "enable cleared");
    end
    @(posedge clk);
    ev <= 11'h040;
    addr <= 12'h400;
    wdata <= 32'hFFFF_FFFF;
    wr_en <= 1'b1;
    @(posedge clk);
    ev <= 11'h000;
    wr_en <= 1'b0;
    rdchk(12'h400, 32'h0000_0200, "flag set beats clear");
    wr(12'h400, 32'h0000_0200);
    $display("test interrupts done");
    complete_run;
  end
endmodule
`default_nettype wire
